/* testbench/amg_config_checker.sv */
// port assertions for the amplifier configuration block
`timescale 1ns/1ps
`default_nettype none
module amg_config_checker
  import amg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins and settings
  input wire logic [1:0] gainSelectPins,
  input wire logic ampShutdownN,
  input wire logic sleepOrAddressPin,
  input wire logic parallelModeOrCtrlClockPin,
  input wire logic [7:0] swAnalogGain,
  // decoded outputs
  input wire logic softwareMode,
  input wire logic [3:0] digitalGainValue,
  input wire logic [7:0] analogGainValue,
  input wire logic [7:0] volumeValue,
  input wire logic ampShutdown,
  input wire logic ampHighZ,
  input wire logic ctrlClockIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [7:0] gainExp = gainSelectPins == 2'h0 ? AMG_AGAIN_CODE00 :
    gainSelectPins == 2'h1 ? AMG_AGAIN_CODE01 : AMG_AGAIN_CODE10;
  boost_fixed_a:
    assert property (!softwareMode |-> digitalGainValue == AMG_DBOOST_HW)
    else $error("boost not fixed in hardware mode");
  gain_decode_a:
    assert property (($stable(gainSelectPins) && gainSelectPins != AMG_CODE_SW) [*5]
      |-> analogGainValue == gainExp)
    else $error("analog gain does not follow pin code");
  sw_enter_a:
    assert property ((gainSelectPins == AMG_CODE_SW) [*5] |-> softwareMode)
    else $error("code 11 did not enter software mode");
  sw_gain_a:
    assert property ((softwareMode && $stable(swAnalogGain)) [*3]
      |-> analogGainValue == swAnalogGain)
    else $error("software gain not applied");
  hw_volume_a:
    assert property (!softwareMode |-> volumeValue == AMG_VOLUME_0DB)
    else $error("volume moved in hardware mode");
  ctrl_clock_a:
    assert property ((softwareMode && $stable(parallelModeOrCtrlClockPin)) [*4]
      |-> ctrlClockIn == parallelModeOrCtrlClockPin)
    else $error("control clock not routed");
  shut_on_a:
    assert property ((!ampShutdownN) [*5] |-> ampShutdown)
    else $error("low shutdown pin ignored");
  shut_off_a:
    assert property (ampShutdownN [*5] |-> !ampShutdown)
    else $error("high shutdown pin ignored");
  sleep_highz_a:
    assert property ((!softwareMode && sleepOrAddressPin) [*4] |-> ampHighZ)
    else $error("sleep did not stop switching");
endmodule // amg_config_checker

bind amg_config amg_config_checker u_chk (
  .clk(clk), .resetn(resetn), .gainSelectPins(gainSelectPins),
  .ampShutdownN(ampShutdownN), .sleepOrAddressPin(sleepOrAddressPin),
  .parallelModeOrCtrlClockPin(parallelModeOrCtrlClockPin), .swAnalogGain(swAnalogGain),
  .softwareMode(softwareMode), .digitalGainValue(digitalGainValue),
  .analogGainValue(analogGainValue), .volumeValue(volumeValue), .ampShutdown(ampShutdown),
  .ampHighZ(ampHighZ), .ctrlClockIn(ctrlClockIn)
);
`default_nettype wire

/* testbench/amg_config_tb_top.sv */
// self-checking bench of the amplifier configuration block
`timescale 1ns/1ps
`default_nettype none
module amg_config_tb_top;
  import amg_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, shutN = 1'b1, sleep = 1'b1, parallel_bridge_mode = 1'b0, swDbl = 1'b0;
  logic pbm, sfh, adr, pinOut;
  logic swDrv = 1'b0, run = 1'b0, rdy = 1'b0, oe, swMode, shut, hiZ, ckIn, dIn, err, vld, ovf;
  logic [1:0] gsel = 2'h0;
  logic [3:0] swDb = 4'h0, dg;
  logic [7:0] swAg = 8'h00, swVol = 8'h00, ag, vol;
  logic [31:0] data;
  amg_fmt_e swFmt = AMG_FMT_I2S;
  wire logic mclk, bclk, fclk, sdat;
  // open-drain data line with a pull-up
  wire logic sdaLine = !oe;
  int failures = 0, nCompared = 0, cycles = 0;
  always #5 clk = ~clk;
  amg_sap_source u_src (.run(run), .masterClk(mclk), .bitClk(bclk), .frameClk(fclk),
    .serialData(sdat));
  amg_config u_dut (.clk(clk), .resetn(resetn), .gainSelectPins(gsel), .ampShutdownN(shutN),
    .sleepOrAddressPin(sleep), .parallelModeOrCtrlClockPin(parallel_bridge_mode),
    .switchFreqOrCtrlDataPinIn(sdaLine), .switchFreqOrCtrlDataPinOut(pinOut),
    .switchFreqOrCtrlDataPinOe(oe), .swAnalogGain(swAg), .swDigitalBoost(swDb),
    .swVolume(swVol), .swFormat(swFmt), .swDoubleSpeed(swDbl), .swCtrlDataDriveLow(swDrv),
    .masterClk(mclk), .bitClk(bclk), .frameClk(fclk), .serialData(sdat),
    .softwareMode(swMode), .digitalGainValue(dg), .analogGainValue(ag), .volumeValue(vol),
    .ampShutdown(shut), .ampHighZ(hiZ), .parallelBridgeMode(pbm), .switchFreqHalf(sfh),
    .ctrlClockIn(ckIn), .ctrlDataIn(dIn), .ctrlAddrBit(adr), .clockError(err),
    .sampleValid(vld), .sampleReady(rdy), .sampleData(data), .sampleOverflow(ovf));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_hw_gain();
    logic [7:0] exp [3];
    exp = '{AMG_AGAIN_CODE00, AMG_AGAIN_CODE01, AMG_AGAIN_CODE10};
    for (int c = 0; c < 3; c++) begin
      gsel = 2'(c);
      wait_cyc(6);
      chk("analogGain", 32'(exp[c]), 32'(ag));
      chk("digitalGain", 32'(AMG_DBOOST_HW), 32'(dg));
      chk("volume", 32'(AMG_VOLUME_0DB), 32'(vol));
    end
    // sleep pin was high through reset: the address strap must have caught it
    chk("addrBit", 32'h1, 32'(adr));
    chk("hwPins", 32'h1, {30'h0, pbm, sfh});
    gsel = 2'h0; // back to the 12 V pairing; code 10 is never left standing
    sleep = 1'b0;
    wait_cyc(6);
    chk("highZ", 32'h0, 32'(hiZ));
  endtask
  task automatic t_shutdown();
    // sleep goes high before the shutdown pin falls
    sleep = 1'b1;
    wait_cyc(6);
    chk("highZ", 32'h1, 32'(hiZ));
    shutN = 1'b0;
    wait_cyc(6);
    chk("shutdown", 32'h1, 32'(shut));
    shutN = 1'b1;
    sleep = 1'b0;
    wait_cyc(6);
    chk("shutdown", 32'h0, 32'(shut));
  endtask
  task automatic t_sw_mode();
    gsel = AMG_CODE_SW;
    swAg = 8'h55;
    swDb = 4'h3;
    swVol = 8'hA0;
    swDrv = 1'b1;
    wait_cyc(8);
    chk("swMode", 32'h1, 32'(swMode));
    chk("swGain", 32'h0055_A003, {8'h0, ag, vol, 4'h0, dg});
    chk("ctrlPins", 32'h0, {30'h0, ckIn, dIn});
    swDrv = 1'b0;
    parallel_bridge_mode = 1'b1;
    wait_cyc(8);
    chk("ctrlPins", 32'h3, {30'h0, ckIn, dIn});
    chk("swPins", 32'h2, {28'h0, pbm, sfh, adr, pinOut});
  endtask
  task automatic t_clock();
    gsel = 2'h1; // lowest code whose swing still covers the target
    run = 1'b1;
    wait_cyc(4096);
    chk("clkErrHw", 32'h1, 32'(err));
    gsel = AMG_CODE_SW;
    swDbl = 1'b1;
    wait_cyc(4096);
    chk("clkErrDbl", 32'h0, 32'(err));
    swDbl = 1'b0;
    wait_cyc(3072);
    chk("clkErrSs", 32'h1, 32'(err));
    swDbl = 1'b1;
    wait_cyc(3072);
    chk("clkErrBack", 32'h0, 32'(err));
  endtask
  task automatic t_formats();
    rdy = 1'b1;
    for (int f = 0; f < 3; f++) begin
      swFmt = amg_fmt_e'(f);
      wait_cyc(2048);
      for (int i = 0; i < 2000 && vld !== 1'b1; i++) @(negedge clk);
      chk("word", 32'hFFFF_FFFF, data);
    end
  endtask
  task automatic t_fifo();
    int n;
    n = 0;
    rdy = 1'b0;
    wait_cyc(18432);
    run = 1'b0;
    wait_cyc(1024);
    chk("overflow", 32'h1, 32'(ovf));
    rdy = 1'b1;
    // far side stalled while filling; now drained until empty
    for (int i = 0; i < 100 && vld === 1'b1; i++) begin
      n++;
      @(negedge clk);
    end
    chk("drained", 32'd32, 32'(n));
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    wait_cyc(5);
    resetn = 1'b1;
    t_hw_gain();
    t_shutdown();
    t_sw_mode();
    t_clock();
    t_formats();
    t_fifo();
    report_and_stop();
  end
endmodule // amg_config_tb_top
`default_nettype wire

/* testbench/amg_sap_source.sv */
// audio processor model sending whole frames on the serial audio port
`timescale 1ns/1ps
`default_nettype none
module amg_sap_source #(
  parameter int BITS_PER_HALF = 32
) (
  // control
  input wire logic run,
  // serial audio pins
  output logic masterClk,
  output logic bitClk,
  output logic frameClk,
  output logic serialData
);
  // 64 bit clocks and 128 master clocks per frame: a double-speed ratio pair
  initial begin
    masterClk = 1'b0;
    bitClk = 1'b0;
    frameClk = 1'b0;
    serialData = 1'b0;
    forever begin
      wait (run);
      repeat (2) begin
        frameClk = ~frameClk;
        repeat (BITS_PER_HALF) begin
          bitClk = 1'b0;
          masterClk = 1'b1;
          serialData = 1'b1;
          #40 masterClk = 1'b0;
          #40 bitClk = 1'b1;
          masterClk = 1'b1;
          #40 masterClk = 1'b0;
          #40;
        end
      end
      // clocks stand still once run is low after a frame; the stopped data line then shows the inverse
      bitClk = 1'b0;
      serialData = ~serialData;
    end
  end
endmodule // amg_sap_source
`default_nettype wire

/* verilog/amg_config.sv */
// mode decode, gain selection, shutdown and serial audio clock check of the amplifier
// How it works
// R1: pin codes give 6 dB boost, three analog gains
// R2: code 11 selects software control gains
// R3: volume fixed at 0 dB in hardware mode
// R4: software mode routes config pins to control port
// R5: shutdown pin low shuts amplifier, high releases
// R6: host raises sleep before pulling shutdown low
// R7: software mode accepts LJ, RJ or I2S
// R8: software double speed allows 88.2/96 kHz
// R9: single speed bit and master clock ratios
// R10: double speed master 64-256, bit 32-64
// R11: host avoids gain code 10
// R12: host pairs code 00/12 V, 01/15 V
// R13: host picks lowest sufficient gain code
// R14: sleep pin in hardware mode stops switching
// R15: bad clock combination keeps outputs silent
// R16: pin code decoded continuously, 11 overrides
`timescale 1ns/1ps
`default_nettype none

module amg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  wire full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  wire empty = (wrPtr_r == rdPtr_r);
  wire doWr = inValid && !full;
  wire doRd = outReady && !empty;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + (AW+1)'(doWr);
      rdPtr_r <= rdPtr_r + (AW+1)'(doRd);
    end
  end
endmodule // amg_fifo

module amg_config #(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = 32,
  parameter int FRAME_12K_MIN = amg_pkg::AMG_FRAME_12K_MIN,
  parameter int FRAME_16K_MIN = amg_pkg::AMG_FRAME_16K_MIN
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration pins
  input wire logic [1:0] gainSelectPins,
  input wire logic ampShutdownN,
  input wire logic sleepOrAddressPin,
  input wire logic parallelModeOrCtrlClockPin,
  input wire logic switchFreqOrCtrlDataPinIn,
  output logic switchFreqOrCtrlDataPinOut,
  output logic switchFreqOrCtrlDataPinOe,
  // settings from the control-port register file
  input wire logic [7:0] swAnalogGain,
  input wire logic [3:0] swDigitalBoost,
  input wire logic [7:0] swVolume,
  input wire amg_pkg::amg_fmt_e swFormat,
  input wire logic swDoubleSpeed,
  input wire logic swCtrlDataDriveLow,
  // serial audio port
  input wire logic masterClk,
  input wire logic bitClk,
  input wire logic frameClk,
  input wire logic serialData,
  // decoded configuration
  output logic softwareMode,
  output logic [3:0] digitalGainValue,
  output logic [7:0] analogGainValue,
  output logic [7:0] volumeValue,
  output logic ampShutdown,
  output logic ampHighZ,
  output logic parallelBridgeMode,
  output logic switchFreqHalf,
  output logic ctrlClockIn,
  output logic ctrlDataIn,
  output logic ctrlAddrBit,
  output logic clockError,
  // sample stream towards the converter
  output logic sampleValid,
  input wire logic sampleReady,
  output logic [DATA_W-1:0] sampleData,
  output logic sampleOverflow
);
  import amg_pkg::*;
  localparam int NS = 10;
  logic [NS-1:0] pinRaw;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NS-1:0] prev_r;
  assign pinRaw = {gainSelectPins, ampShutdownN, sleepOrAddressPin, parallelModeOrCtrlClockPin,
                   switchFreqOrCtrlDataPinIn, masterClk, bitClk, frameClk, serialData};
  // every pin passes two flops; the second stage is looked at, and a third flop after it gives the clock edges
  genvar gi;
  for (gi = 0; gi < NS; gi++) begin : g_sync
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        sync1_r[gi] <= 1'b0;
        sync2_r[gi] <= 1'b0;
        prev_r[gi] <= 1'b0;
      end else begin
        sync1_r[gi] <= pinRaw[gi];
        sync2_r[gi] <= sync1_r[gi];
        prev_r[gi] <= sync2_r[gi];
      end
    end
  end
  wire [1:0] gainCode = sync2_r[9:8];
  wire sdN = sync2_r[7];
  wire sleepPin = sync2_r[6];
  wire pbtlPin = sync2_r[5];
  wire sdaPin = sync2_r[4];
  wire mclkRise = sync2_r[3] && !prev_r[3];
  wire sclkRise = sync2_r[2] && !prev_r[2];
  wire frameRise = sync2_r[1] && !prev_r[1];
  wire frameEdge = sync2_r[1] != prev_r[1];
  wire sdinBit = sync2_r[0];

  // gain and mode decode
  wire swSel = (gainCode == AMG_CODE_SW); // [R2] [R16]
  wire [7:0] hwAnalog = (gainCode == 2'h0000) ? AMG_AGAIN_CODE00 :
                        (gainCode == 2'h0001) ? AMG_AGAIN_CODE01 : AMG_AGAIN_CODE10; // [R1]
  wire [7:0] analogNxt = swSel ? swAnalogGain : hwAnalog; // [R2] [R16]
  wire [3:0] boostNxt = swSel ? swDigitalBoost : AMG_DBOOST_HW; // [R1]
  wire [7:0] volumeNxt = swSel ? swVolume : AMG_VOLUME_0DB; // [R3]
  wire doubleSpeed = swSel && swDoubleSpeed; // [R8]
  wire amg_fmt_e fmtNow = swSel ? swFormat : AMG_FMT_I2S; // [R7]

  // frame-length measurement and per-frame edge counts
  logic [13:0] frameCnt_r;
  logic [9:0] mclkCnt_r;
  logic [9:0] sclkCnt_r;
  logic clkErr_r;
  logic [1:0] addrWait_r;
  wire amg_rate_e rateNow =
    (frameCnt_r >= 14'(FRAME_12K_MIN)) ? AMG_RATE_12K :
    (frameCnt_r >= 14'(FRAME_16K_MIN)) ? AMG_RATE_16K :
    (frameCnt_r >= 14'(AMG_FRAME_24K_MIN)) ? AMG_RATE_24K :
    (frameCnt_r >= 14'(AMG_FRAME_SS_MIN)) ? AMG_RATE_32UP : AMG_RATE_DBL;
  wire bclkOk = (sclkCnt_r == AMG_BCLK_32) || (sclkCnt_r == AMG_BCLK_48) ||
                (sclkCnt_r == AMG_BCLK_64); // [R9] [R10]
  wire mclkStd = (mclkCnt_r == AMG_MCLK_128) || (mclkCnt_r == AMG_MCLK_192) ||
                 (mclkCnt_r == AMG_MCLK_256) || (mclkCnt_r == AMG_MCLK_384) ||
                 (mclkCnt_r == AMG_MCLK_512);
  logic mclkOk;
  always_comb begin
    unique case (rateNow)
      AMG_RATE_12K: mclkOk = !doubleSpeed && (mclkCnt_r == AMG_MCLK_512); // [R9]
      AMG_RATE_16K: mclkOk = !doubleSpeed && mclkStd && (mclkCnt_r >= AMG_MCLK_256); // [R9]
      AMG_RATE_24K: mclkOk = !doubleSpeed && mclkStd && (mclkCnt_r >= AMG_MCLK_192); // [R9]
      AMG_RATE_32UP: mclkOk = !doubleSpeed && mclkStd; // [R9]
      AMG_RATE_DBL: mclkOk = doubleSpeed && ((mclkCnt_r == AMG_MCLK_64) ||
        (mclkCnt_r == AMG_MCLK_128) || (mclkCnt_r == AMG_MCLK_192) ||
        (mclkCnt_r == AMG_MCLK_256)); // [R10]
      default: mclkOk = 1'b0;
    endcase
  end
  // a frame that never ends also counts as a clock fault
  wire frameStuck = &frameCnt_r;
  wire clkErrNxt = frameRise ? !(bclkOk && mclkOk) : (clkErr_r || frameStuck); // [R15]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frameCnt_r <= '0;
      mclkCnt_r <= '0;
      sclkCnt_r <= '0;
      clkErr_r <= 1'b1;
    end else begin
      frameCnt_r <= frameRise ? 14'h0000 : (frameStuck ? frameCnt_r : frameCnt_r + 14'h0001);
      // a rise that lands with the frame rise opens the new frame, so it counts there
      mclkCnt_r <= frameRise ? 10'(mclkRise) : mclkCnt_r + 10'(mclkRise && !(&mclkCnt_r));
      sclkCnt_r <= frameRise ? 10'(sclkRise) : sclkCnt_r + 10'(sclkRise && !(&sclkCnt_r));
      clkErr_r <= clkErrNxt;
    end
  end

  // serial data capture per channel half-frame
  logic [5:0] bitCnt_r;
  logic [DATA_W-1:0] shift_r;
  wire [5:0] skip = (fmtNow == AMG_FMT_I2S) ? 6'h0001 : 6'h0000; // [R7]
  wire inWindow = (fmtNow == AMG_FMT_RJ) ||
                  ((bitCnt_r >= skip) && (bitCnt_r < skip + 6'(DATA_W))); // [R7]
  wire silent = clkErr_r || !sdN || ampHighZ; // [R15]
  wire pushValid = frameEdge;
  wire pushReady;
  wire [DATA_W-1:0] pushData = silent ? '0 : shift_r; // [R15]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_r <= '0;
      shift_r <= '0;
    end else if (frameEdge) begin
      bitCnt_r <= '0;
    end else if (sclkRise) begin
      bitCnt_r <= (&bitCnt_r) ? bitCnt_r : bitCnt_r + 6'h0001;
      if (inWindow) begin
        shift_r <= {shift_r[DATA_W-2:0], sdinBit};
      end
    end
  end
  amg_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(sampleValid),
    .outReady(sampleReady),
    .outData(sampleData)
  );

  // registered configuration outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      softwareMode <= 1'b0;
      digitalGainValue <= AMG_DBOOST_HW;
      analogGainValue <= AMG_AGAIN_CODE00;
      volumeValue <= AMG_VOLUME_0DB;
      ampShutdown <= 1'b1;
      ampHighZ <= 1'b1;
      parallelBridgeMode <= 1'b0;
      switchFreqHalf <= 1'b0;
      ctrlClockIn <= 1'b1;
      ctrlDataIn <= 1'b1;
      switchFreqOrCtrlDataPinOut <= 1'b0;
      switchFreqOrCtrlDataPinOe <= 1'b0;
      ctrlAddrBit <= 1'b0;
      addrWait_r <= 2'h0;
      clockError <= 1'b1;
      sampleOverflow <= 1'b0;
    end else begin
      softwareMode <= swSel; // [R2] [R16]
      digitalGainValue <= boostNxt; // [R1]
      analogGainValue <= analogNxt; // [R1] [R16]
      volumeValue <= volumeNxt; // [R3]
      ampShutdown <= !sdN; // [R5]
      // sleep stops switching in hardware mode; in software mode the pin is an address strap
      ampHighZ <= !swSel && sleepPin; // [R14]
      parallelBridgeMode <= !swSel && pbtlPin;
      switchFreqHalf <= !swSel && sdaPin;
      ctrlClockIn <= swSel ? pbtlPin : 1'b1; // [R4]
      ctrlDataIn <= swSel ? sdaPin : 1'b1; // [R4]
      switchFreqOrCtrlDataPinOe <= swSel && swCtrlDataDriveLow; // [R4]
      // address strap taken once, after the synchroniser has settled
      // the second stage holds the pin from the second edge on, so take it at the third
      addrWait_r <= (&addrWait_r) ? addrWait_r : addrWait_r + 2'h1;
      if (addrWait_r == 2'h2) begin
        ctrlAddrBit <= sleepPin;
      end
      clockError <= clkErrNxt; // [R15]
      sampleOverflow <= sampleOverflow || (pushValid && !pushReady);
    end
  end
endmodule // amg_config

`default_nettype wire

/* verilog/amg_pkg.sv */
// constants shared by the amplifier mode, gain and serial audio clocking block
package amg_pkg;
  // analog gain values in tenths of a dBV
  localparam logic [7:0] AMG_AGAIN_CODE00 = 8'h00_C0; // 19.2 dBV
  localparam logic [7:0] AMG_AGAIN_CODE01 = 8'h00_E2; // 22.6 dBV
  localparam logic [7:0] AMG_AGAIN_CODE10 = 8'h00_FA; // 25.0 dBV
  // digital boost in dB and default volume code
  localparam logic [3:0] AMG_DBOOST_HW = 4'h0006;
  localparam logic [7:0] AMG_VOLUME_0DB = 8'h0000;
  // gain-select pin code that hands control to the control port
  localparam logic [1:0] AMG_CODE_SW = 2'h0003;
  // serial data formats
  typedef enum logic [1:0] {
    AMG_FMT_I2S = 2'b00,
    AMG_FMT_LJ = 2'b01,
    AMG_FMT_RJ = 2'b10
  } amg_fmt_e;
  // sample-rate classes found from the frame length
  typedef enum logic [2:0] {
    AMG_RATE_12K = 3'b000,
    AMG_RATE_16K = 3'b001,
    AMG_RATE_24K = 3'b010,
    AMG_RATE_32UP = 3'b011,
    AMG_RATE_DBL = 3'b100
  } amg_rate_e;
  // edges per frame that the clock check accepts
  localparam logic [9:0] AMG_BCLK_32 = 10'h0020;
  localparam logic [9:0] AMG_BCLK_48 = 10'h0030;
  localparam logic [9:0] AMG_BCLK_64 = 10'h0040;
  localparam logic [9:0] AMG_MCLK_64 = 10'h0040;
  localparam logic [9:0] AMG_MCLK_128 = 10'h0080;
  localparam logic [9:0] AMG_MCLK_192 = 10'h00C0;
  localparam logic [9:0] AMG_MCLK_256 = 10'h0100;
  localparam logic [9:0] AMG_MCLK_384 = 10'h0180;
  localparam logic [9:0] AMG_MCLK_512 = 10'h0200;
  // frame-length bands in 10 ns cycles (12k=8333, 16k=6250, 24k=4167, 88.2k=1134)
  localparam int AMG_FRAME_12K_MIN = 7000;
  localparam int AMG_FRAME_16K_MIN = 5000;
  localparam int AMG_FRAME_24K_MIN = 3500;
  localparam int AMG_FRAME_SS_MIN = 1500;
endpackage : amg_pkg
